// File: logic/ims_defines.svh
// Constants for the isolated modulator sampling sequencer
`ifndef IMS_DEFINES_SVH
`define IMS_DEFINES_SVH
`define IMS_CORE_HZ        200000000
`define IMS_SYS_HZ         19798016
`define IMS_MOD_DIV        ((`IMS_CORE_HZ + `IMS_SYS_HZ - 1) / `IMS_SYS_HZ)
`define IMS_OSR            1024
`define IMS_KEEP_RATIO     4
`define IMS_SAR_HZ         4000000
`define IMS_SAR_DIV        (`IMS_CORE_HZ / `IMS_SAR_HZ)
`define IMS_SAR_SH_CYC     8
`define IMS_SAR_CONV_CYC   12
`define IMS_SCAN_LEN       6
`define IMS_CH_TEMP        4'hA
`define IMS_CH_V1          4'h5
`define IMS_CH_V2          4'h4
`define IMS_CH_V3          4'h3
`endif

// File: logic/ims_pkg.sv
// Types for the isolated modulator sampling sequencer
package ims_pkg;
  typedef enum logic [1:0] {
    IMS_SAR_IDLE = 2'b00,
    IMS_SAR_HOLD = 2'b01,
    IMS_SAR_CONV = 2'b11,
    IMS_SAR_NEXT = 2'b10
  } ims_sar_state_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] ch0;
    logic [15:0] ch1;
    logic [15:0] ch2;
  } ims_cur_sample_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  slot;
    logic [3:0]  chan;
    logic [15:0] data;
  } ims_sar_result_t;
endpackage

// File: logic/ims_cic_filter.sv
// Third-order sinc decimation filter for one single-bit stream
`timescale 1ns/1ps
`include "ims_defines.svh"
module ims_cic_filter #(
  parameter int OSR = `IMS_OSR
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        mod_tick,
  input  wire logic        bit_in,
  input  wire logic        dec_tick,
  output logic [15:0]      sample
);
  localparam int LOG = $clog2(OSR);
  // Never narrower than the 16-bit output word, so small ratios still slice cleanly
  localparam int W   = (3 * LOG + 1 < 16) ? 16 : 3 * LOG + 1;
  if (OSR < 4 || (1 << LOG) != OSR) begin : g_bad_osr
    $error("OSR must be a power of two");
  end
  logic [W-1:0] i1_reg, i2_reg, i3_reg;
  logic [W-1:0] d1_reg, d2_reg, d3_reg;
  logic [W-1:0] c1, c2, c3;
  logic [W-1:0] x;
  assign x  = bit_in ? W'(1) : W'(0);
  assign c1 = i3_reg - d1_reg;
  assign c2 = c1 - d2_reg;
  assign c3 = c2 - d3_reg;

  // Integrators at modulation rate
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      i1_reg <= '0;
      i2_reg <= '0;
      i3_reg <= '0;
    end else if (mod_tick) begin
      i1_reg <= i1_reg + x;
      i2_reg <= i2_reg + i1_reg;
      i3_reg <= i3_reg + i2_reg;
    end
  end

  // Combs at decimated rate, output offset to two's complement
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      d1_reg <= '0;
      d2_reg <= '0;
      d3_reg <= '0;
      sample <= 16'h0000;
    end else if (dec_tick) begin
      d1_reg <= i3_reg;
      d2_reg <= c1;
      d3_reg <= c2;
      sample <= c3[W-1 -: 16] ^ 16'h8000;
    end
  end
endmodule

// File: logic/ims_sequencer.sv
// Modulator clocking, current filters, sample skip and SAR scan sequencing
`timescale 1ns/1ps
`include "ims_defines.svh"
module ims_sequencer #(
  parameter int OSR      = `IMS_OSR,
  parameter int MOD_DIV  = `IMS_MOD_DIV,
  parameter int SAR_DIV  = `IMS_SAR_DIV
) (
  input  wire logic                     CORE_CLK,
  input  wire logic                     ARST_N,
  input  wire logic                     GROUP_START,
  input  wire logic                     RESULT_FORMAT_SELECT,
  input  wire logic                     FILTER0_BITSTREAM_IN,
  input  wire logic                     FILTER1_BITSTREAM_IN,
  input  wire logic                     FILTER2_BITSTREAM_IN,
  input  wire logic [9:0]               SAR_RAW_DATA,
  output logic                          MODULATION_CLOCK_OUT,
  output logic                          SAR_CLOCK_OUT,
  output logic                          TRIGGER_PULSE,
  output ims_pkg::ims_cur_sample_t      CUR_SAMPLE,
  output logic [3:0]                    SAR_CHANNEL_SEL,
  output ims_pkg::ims_sar_result_t      SAR_RESULT,
  output logic                          SCAN_TRANSFER_DONE_FLAG
);
  // Divider counters are eight bits wide
  if (MOD_DIV < 2 || SAR_DIV < 2 || MOD_DIV > 256 || SAR_DIV > 256) begin : g_bad_div
    $error("Clock dividers must lie between 2 and 256");
  end
  if (OSR < 4) begin : g_bad_osr
    $error("OSR too small");
  end

  function automatic logic [3:0] scan_chan(input logic [2:0] slot);
    case (slot)
      3'h0:    scan_chan = `IMS_CH_TEMP;
      3'h1:    scan_chan = `IMS_CH_V1;
      3'h2:    scan_chan = `IMS_CH_V2;
      3'h3:    scan_chan = `IMS_CH_V3;
      // Slots 4 and 5 scan channels 6 and 7, none repeated
      default: scan_chan = 4'(slot) + 4'h2;
    endcase
  endfunction

  // Group run state: modulation clock and filters held until started together; SAR clock runs free
  logic run_reg;
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) run_reg <= 1'b0;
    else if (GROUP_START) run_reg <= 1'b1;
  end

  // Modulation clock divider from core clock
  logic [7:0] mdiv_reg;
  logic       mod_tick;
  assign mod_tick = run_reg && (mdiv_reg == 8'(MOD_DIV - 1)) && MODULATION_CLOCK_OUT;
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mdiv_reg             <= 8'h00;
      MODULATION_CLOCK_OUT <= 1'b0;
    end else if (!run_reg) begin
      mdiv_reg             <= 8'h00;
      MODULATION_CLOCK_OUT <= 1'b0;
    end else if (mdiv_reg == 8'(MOD_DIV - 1)) begin
      mdiv_reg             <= 8'h00;
      MODULATION_CLOCK_OUT <= ~MODULATION_CLOCK_OUT;
    end else begin
      mdiv_reg <= mdiv_reg + 8'h01;
    end
  end

  // Decimation counter shared by filters and trigger generator
  localparam int OW = $clog2(OSR);
  logic [OW-1:0] osr_reg;
  logic          dec_tick;
  assign dec_tick = mod_tick && (osr_reg == OW'(OSR - 1));
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) osr_reg <= '0;
    else if (mod_tick) osr_reg <= osr_reg + OW'(1);
  end

  // Three filters sharing one reset and one decimation tick
  logic [2:0]  bits_in;
  logic [15:0] filt [3];
  assign bits_in = {FILTER2_BITSTREAM_IN, FILTER1_BITSTREAM_IN, FILTER0_BITSTREAM_IN};
  for (genvar g = 0; g < 3; g++) begin : g_filt
    ims_cic_filter #(.OSR(OSR)) u_filt (
      .clk      (CORE_CLK),
      .arst_n   (ARST_N),
      .mod_tick (mod_tick),
      .bit_in   (bits_in[g]),
      .dec_tick (dec_tick),
      .sample   (filt[g])
    );
  end

  // Trigger and modulo-four keep counter; delayed one cycle after filter output
  logic       dec_d_reg;
  logic [1:0] skip_reg;
  logic       keep;
  assign keep = dec_d_reg && (skip_reg == 2'h0);
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dec_d_reg     <= 1'b0;
      skip_reg      <= 2'h0;
      TRIGGER_PULSE <= 1'b0;
    end else begin
      dec_d_reg     <= dec_tick;
      TRIGGER_PULSE <= dec_d_reg;
      if (dec_d_reg) skip_reg <= skip_reg + 2'h1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CUR_SAMPLE <= '0;
    end else begin
      CUR_SAMPLE.valid <= keep;
      if (keep) begin
        CUR_SAMPLE.ch0 <= filt[0];
        CUR_SAMPLE.ch1 <= filt[1];
        CUR_SAMPLE.ch2 <= filt[2];
      end
    end
  end

  // SAR clock at 4 MHz
  logic [7:0] sdiv_reg;
  logic       sar_tick;
  assign sar_tick = (sdiv_reg == 8'(SAR_DIV - 1));
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sdiv_reg      <= 8'h00;
      SAR_CLOCK_OUT <= 1'b0;
    end else begin
      sdiv_reg      <= sar_tick ? 8'h00 : sdiv_reg + 8'h01;
      SAR_CLOCK_OUT <= (sdiv_reg < 8'(SAR_DIV / 2));
    end
  end

  // SAR autoscan sequencer
  ims_pkg::ims_sar_state_t st_reg;
  logic [4:0] cyc_reg;
  logic [2:0] slot_reg;
  logic       pend_reg;
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) pend_reg <= 1'b0;
    else if (keep) pend_reg <= 1'b1;
    else if (st_reg == ims_pkg::IMS_SAR_IDLE && sar_tick) pend_reg <= 1'b0;
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_reg   <= ims_pkg::IMS_SAR_IDLE;
      cyc_reg  <= 5'h00;
      slot_reg <= 3'h0;
    end else if (sar_tick) begin
      case (st_reg)
        ims_pkg::IMS_SAR_IDLE: begin
          slot_reg <= 3'h0;
          cyc_reg  <= 5'h00;
          if (pend_reg) st_reg <= ims_pkg::IMS_SAR_HOLD;
        end
        ims_pkg::IMS_SAR_HOLD: begin
          if (cyc_reg == 5'(`IMS_SAR_SH_CYC - 1)) begin
            cyc_reg <= 5'h00;
            st_reg  <= ims_pkg::IMS_SAR_CONV;
          end else cyc_reg <= cyc_reg + 5'h01;
        end
        ims_pkg::IMS_SAR_CONV: begin
          if (cyc_reg == 5'(`IMS_SAR_CONV_CYC - 1)) begin
            cyc_reg <= 5'h00;
            st_reg  <= ims_pkg::IMS_SAR_NEXT;
          end else cyc_reg <= cyc_reg + 5'h01;
        end
        ims_pkg::IMS_SAR_NEXT: begin
          if (slot_reg == 3'(`IMS_SCAN_LEN - 1)) begin
            st_reg <= ims_pkg::IMS_SAR_IDLE;
          end else begin
            slot_reg <= slot_reg + 3'h1;
            st_reg   <= ims_pkg::IMS_SAR_HOLD;
          end
        end
        default: st_reg <= ims_pkg::IMS_SAR_IDLE;
      endcase
    end
  end

  // Result capture, formatting and scan completion
  logic conv_end;
  assign conv_end = sar_tick && st_reg == ims_pkg::IMS_SAR_CONV
                    && cyc_reg == 5'(`IMS_SAR_CONV_CYC - 1);
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SAR_RESULT              <= '0;
      SAR_CHANNEL_SEL         <= `IMS_CH_TEMP;
      SCAN_TRANSFER_DONE_FLAG <= 1'b0;
    end else begin
      SAR_CHANNEL_SEL  <= scan_chan(slot_reg);
      SAR_RESULT.valid <= conv_end;
      if (conv_end) begin
        SAR_RESULT.slot <= slot_reg;
        SAR_RESULT.chan <= scan_chan(slot_reg);
        SAR_RESULT.data <= RESULT_FORMAT_SELECT ?
                           {~SAR_RAW_DATA[9], SAR_RAW_DATA[8:0], 6'h00} :
                           {6'h00, SAR_RAW_DATA};
      end
      SCAN_TRANSFER_DONE_FLAG <= conv_end && slot_reg == 3'(`IMS_SCAN_LEN - 1);
    end
  end
endmodule

// File: tb/ims_seq_properties.sv
// Port properties of the sampling sequencer
`timescale 1ns/1ps
module ims_seq_properties #(
  parameter int OSR     = 1024,
  parameter int MOD_DIV = 11,
  parameter int SAR_DIV = 50
) (
  input wire logic                     CORE_CLK,
  input wire logic                     ARST_N,
  input wire logic                     RESULT_FORMAT_SELECT,
  input wire logic                     MODULATION_CLOCK_OUT,
  input wire logic                     TRIGGER_PULSE,
  input wire ims_pkg::ims_cur_sample_t CUR_SAMPLE,
  input wire ims_pkg::ims_sar_result_t SAR_RESULT,
  input wire logic                     SCAN_TRANSFER_DONE_FLAG
);
  localparam logic [23:0] CHAN_MAP = 24'h76345A;
  logic [1:0] tcnt_reg;
  logic       tseen_reg;
  logic       mseen_reg;
  int         tgap_reg;
  int         mgap_reg;
  int         rgap_reg;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  // Cycle gaps since the last trigger, clock toggle and result
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tcnt_reg  <= 2'h0;
      tseen_reg <= 1'b0;
      mseen_reg <= 1'b0;
      tgap_reg  <= 0;
      mgap_reg  <= 0;
      rgap_reg  <= 0;
    end else begin
      tcnt_reg  <= tcnt_reg + {1'b0, TRIGGER_PULSE};
      tseen_reg <= tseen_reg | TRIGGER_PULSE;
      mseen_reg <= mseen_reg | $changed(MODULATION_CLOCK_OUT);
      tgap_reg  <= TRIGGER_PULSE ? 1 : tgap_reg + 1;
      mgap_reg  <= $changed(MODULATION_CLOCK_OUT) ? 1 : mgap_reg + 1;
      rgap_reg  <= SAR_RESULT.valid ? 1 : rgap_reg + 1;
    end
  end
  chk_trig_single: assert property (TRIGGER_PULSE |=> !TRIGGER_PULSE)
    else $error("trigger too long");
  chk_trig_period: assert property (TRIGGER_PULSE && tseen_reg |->
    tgap_reg == OSR * 2 * MOD_DIV) else $error("trigger period");
  chk_keep_phase: assert property (TRIGGER_PULSE |->
    CUR_SAMPLE.valid == (tcnt_reg == 2'h0)) else $error("kept phase");
  chk_mod_half: assert property ($changed(MODULATION_CLOCK_OUT) && mseen_reg |->
    mgap_reg == MOD_DIV) else $error("modulation clock period");
  // Hold 8, convert 12, advance 1 SAR clock per slot
  chk_slot_gap: assert property (SAR_RESULT.valid && SAR_RESULT.slot != 3'h0 |->
    rgap_reg == 21 * SAR_DIV) else $error("slot spacing");
  chk_chan_map: assert property (SAR_RESULT.valid |->
    SAR_RESULT.chan == CHAN_MAP[{SAR_RESULT.slot, 2'h0} +: 4]) else $error("channel map");
  chk_fmt_shape: assert property (SAR_RESULT.valid |-> (RESULT_FORMAT_SELECT ?
    SAR_RESULT.data[5:0] == 6'h0 : SAR_RESULT.data[15:10] == 6'h0)) else $error("format");
  chk_done_last: assert property (SCAN_TRANSFER_DONE_FLAG |->
    SAR_RESULT.valid && SAR_RESULT.slot == 3'h5) else $error("done flag");
endmodule
bind ims_sequencer ims_seq_properties #(.OSR(OSR), .MOD_DIV(MOD_DIV), .SAR_DIV(SAR_DIV)) u_props (
  .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .RESULT_FORMAT_SELECT(RESULT_FORMAT_SELECT),
  .MODULATION_CLOCK_OUT(MODULATION_CLOCK_OUT), .TRIGGER_PULSE(TRIGGER_PULSE),
  .CUR_SAMPLE(CUR_SAMPLE), .SAR_RESULT(SAR_RESULT),
  .SCAN_TRANSFER_DONE_FLAG(SCAN_TRANSFER_DONE_FLAG));

// File: tb/ims_modulator_model.sv
// Model of three isolated delta-sigma modulators
`timescale 1ns/1ps
module ims_modulator_model (
  input  wire logic  mod_clk,
  input  wire logic  arst_n,
  output logic [2:0] bits
);
  logic [2:0] step_reg;
  always_ff @(posedge mod_clk or negedge arst_n) begin
    if (!arst_n) begin
      step_reg <= 3'h0;
    end else begin
      step_reg <= step_reg + 3'h1;
    end
  end
  // Phase A dense ones, B mid-scale, C sparse
  assign bits = {step_reg == 3'h0, step_reg[0], step_reg != 3'h0};
endmodule

// File: tb/ims_sequencer_bench.sv
// Self-checking bench for the sampling sequencer
`timescale 1ns/1ps
module ims_sequencer_bench;
  logic                     clk;
  logic                     arst_n;
  logic                     start;
  logic                     fmt;
  logic [9:0]               raw;
  logic                     mclk;
  logic                     trig;
  logic                     done;
  logic [2:0]               bits;
  logic [3:0]               sel;
  logic                     sclk;
  logic                     sclk_d;
  ims_pkg::ims_cur_sample_t cur;
  ims_pkg::ims_sar_result_t res;
  int                       fail_count;
  int                       checked;
  int                       n_res;
  int                       n_done;
  int                       r0;
  int                       d0;
  int                       n_rise;
  int                       k0;
  // Channel scanned per slot, slot zero in the low nibble
  localparam logic [23:0]   chan_map = 24'h76345A;
  // Format, raw code, expected word
  logic [26:0] rows [8] = '{{1'b0, 10'h000, 16'h0000}, {1'b0, 10'h3FF, 16'h03FF},
    {1'b0, 10'h200, 16'h0200}, {1'b0, 10'h155, 16'h0155}, {1'b1, 10'h000, 16'h8000},
    {1'b1, 10'h3FF, 16'h7FC0}, {1'b1, 10'h200, 16'h0000}, {1'b1, 10'h155, 16'hD540}};
  ims_sequencer #(.OSR(16), .MOD_DIV(11), .SAR_DIV(4)) u_dut (
    .CORE_CLK(clk), .ARST_N(arst_n), .GROUP_START(start), .RESULT_FORMAT_SELECT(fmt),
    .FILTER0_BITSTREAM_IN(bits[0]), .FILTER1_BITSTREAM_IN(bits[1]),
    .FILTER2_BITSTREAM_IN(bits[2]), .SAR_RAW_DATA(raw), .MODULATION_CLOCK_OUT(mclk),
    .SAR_CLOCK_OUT(sclk), .TRIGGER_PULSE(trig), .CUR_SAMPLE(cur), .SAR_CHANNEL_SEL(sel),
    .SAR_RESULT(res), .SCAN_TRANSFER_DONE_FLAG(done));
  ims_modulator_model u_mod (.mod_clk(mclk), .arst_n(arst_n), .bits(bits));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    n_res <= n_res + (res.valid === 1'b1);
    n_done <= n_done + (done === 1'b1);
    sclk_d <= sclk;
    n_rise <= n_rise + (sclk === 1'b1 && sclk_d === 1'b0);
  end
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_ev(bit sar);
    int n;
    n = 0;
    @(negedge clk);
    while ((sar ? res.valid : trig) !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check("event wait", n < 3000, 1);
  endtask
  task automatic hold_reset();
    arst_n <= 1'b0;
    repeat (8) @(posedge clk);
    check("reset state", {mclk, trig, cur.valid, res.valid, done, sel}, 9'h00A);
    arst_n <= 1'b1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end
  initial begin
    start = 1'b0;
    fmt = 1'b0;
    raw = 10'h000;
    hold_reset();
    repeat (100) @(posedge clk);
    check("idle before start", {mclk, trig, sel}, 6'h0A);
    k0 = n_rise;
    repeat (400) @(posedge clk);
    check("sar clock edges", n_rise - k0, 100);
    start <= 1'b1;
    wait_ev(0);
    d0 = n_done;
    r0 = n_res;
    for (int i = 0; i < 8; i++) begin
      check("kept", cur.valid, (i % 4) == 0);
      if (i == 4) begin
        check("phase order", {$signed(cur.ch0) > $signed(cur.ch1),
          $signed(cur.ch1) > $signed(cur.ch2)}, 2'h3);
      end
      wait_ev(0);
    end
    check("scans", n_done - d0, 2);
    check("results", n_res - r0, 12);
    foreach (rows[i]) begin
      wait_ev(1);
      @(posedge clk);
      {fmt, raw} <= rows[i][26:16];
      wait_ev(1);
      check("sar word", res.data, rows[i][15:0]);
      check("channel select", sel, chan_map[{res.slot, 2'h0} +: 4]);
    end
    @(posedge clk);
    hold_reset();
    wait_ev(0);
    check("kept after reset", cur.valid, 1);
    wrap_up();
  end
endmodule
